// >>> hdl/iop_pkg.sv
package iop_pkg;
   // register offsets
   localparam logic [7:0] ADDR_D_DIR  = 8'h03;
   localparam logic [7:0] ADDR_C_DATA = 8'h07;
   localparam logic [7:0] ADDR_D_DATA = 8'h08;
   localparam logic [7:0] ADDR_E_DATA = 8'h09;
   localparam logic [7:0] ADDR_C_DIR  = 8'h87;
   localparam logic [7:0] ADDR_E_CTL  = 8'h89;
   localparam logic [7:0] ADDR_ANA    = 8'h9f;

   // fields of the port e direction and slave status register
   localparam int IBF_POS  = 7;
   localparam int OBF_POS  = 6;
   localparam int INPUT_OVERFLOW_FLAG_POS = 5;
   localparam int MODE_POS = 4;
   localparam int NC_POS   = 3;

   // values after reset
   localparam logic [7:0] RST_C_DIR = 8'hff;
   localparam logic [7:0] RST_D_DIR = 8'hff;
   localparam logic [7:0] RST_E_CTL = 8'h07;
   localparam logic [7:0] RST_LATCH = 8'h00;
   localparam logic [2:0] RST_ANA   = 3'h0;

   // pin synchroniser: {port e, port d, port c}; e idles high
   localparam int          SYNC_W    = 19;
   localparam logic [18:0] SYNC_INIT = 19'h70000;

   typedef enum logic [1:0] {
      IOP_IDLE  = 2'b00,
      IOP_WRITE = 2'b01,
      IOP_READ  = 2'b10
   } iop_psp_state_t;

   // analog mask of the three port e pins from the config field
   function automatic logic [2:0] iop_pe_analog(input logic [2:0] cfg);
      iop_pe_analog = (cfg[2:1] == 2'b11) ? 3'h0 : 3'h7;
   endfunction : iop_pe_analog
endpackage : iop_pkg

// >>> hdl/iop_psp_if.sv
`timescale 1ns/1ps
`default_nettype none
interface iop_psp_if;
   logic mode;
   logic cs_n;
   logic rd_n;
   logic wr_n;
   logic rd_act;
   logic wr_act;
   logic wr_end;
   logic rd_start;
   modport ctl  (input mode, cs_n, rd_n, wr_n,
                 output rd_act, wr_act, wr_end, rd_start);
   modport core (output mode, cs_n, rd_n, wr_n,
                 input rd_act, wr_act, wr_end, rd_start);
endinterface : iop_psp_if
`default_nettype wire

// >>> hdl/iop_sync.sv
`timescale 1ns/1ps
`default_nettype none
module iop_sync #(
   parameter int             W    = 8,
   parameter logic [W-1:0]   INIT = '0
) (
   input  wire logic         core_clk,
   input  wire logic         reset,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } iop_sync_st_t;

   iop_sync_st_t st;
   iop_sync_st_t next_st;

   always_comb begin
      next_st    = st;
      next_st.s1 = d;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      // take a level only once stages two and three agree
      next_st.q  = (st.s2 & st.s3) | (st.q & (st.s2 | st.s3));
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         st <= '{INIT, INIT, INIT, INIT};
      end else begin
         st <= next_st;
      end
   end

   assign q = st.q;

   // per bit: a bit in transit must not trip the check of another bit
   a_sync_agree: assert property (
      @(posedge core_clk) disable iff (reset)
      ((q ^ $past(q)) & (($past(st.s2) ^ q) | ($past(st.s3) ^ q))) == '0)
      else $error("synchronised level changed without agreement");
endmodule : iop_sync
`default_nettype wire

// >>> hdl/iop_psp.sv
`timescale 1ns/1ps
`default_nettype none
module iop_psp (
   input  wire logic core_clk,
   input  wire logic reset,
   iop_psp_if.ctl    bus
);
   import iop_pkg::*;

   typedef struct packed {
      iop_psp_state_t state;
      logic           rd_act;
      logic           wr_act;
      logic           wr_end;
      logic           rd_start;
   } iop_psp_st_t;

   iop_psp_st_t st;
   iop_psp_st_t next_st;
   logic        sel;

   assign sel = bus.mode & ~bus.cs_n;

   always_comb begin
      next_st          = st;
      next_st.wr_end   = 1'b0;
      next_st.rd_start = 1'b0;
      unique case (st.state)
         IOP_IDLE: begin
            // a write wins when both strobes fall together
            if (sel && !bus.wr_n) begin
               next_st.state = IOP_WRITE;
            end else if (sel && !bus.rd_n) begin
               next_st.state    = IOP_READ;
               next_st.rd_start = 1'b1;
            end
         end
         IOP_WRITE: begin
            if (!sel || bus.wr_n) begin
               next_st.state  = IOP_IDLE;
               next_st.wr_end = 1'b1;
            end
         end
         IOP_READ: begin
            if (!sel || bus.rd_n) begin
               next_st.state = IOP_IDLE;
            end
         end
         default: next_st.state = IOP_IDLE;
      endcase
      next_st.rd_act = (next_st.state == IOP_READ);
      next_st.wr_act = (next_st.state == IOP_WRITE);
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         st <= '{IOP_IDLE, 1'b0, 1'b0, 1'b0, 1'b0};
      end else begin
         st <= next_st;
      end
   end

   assign bus.rd_act   = st.rd_act;
   assign bus.wr_act   = st.wr_act;
   assign bus.wr_end   = st.wr_end;
   assign bus.rd_start = st.rd_start;

   a_unsel_idle: assert property (
      @(posedge core_clk) disable iff (reset)
      !sel |=> (!bus.rd_act && !bus.wr_act))
      else $error("strobes acted without chip select");

   a_wr_end: assert property (
      @(posedge core_clk) disable iff (reset)
      bus.wr_end |-> ($past(bus.wr_act) && !bus.wr_act))
      else $error("write end without a write in progress");
endmodule : iop_psp
`default_nettype wire

// >>> hdl/iop_ports.sv
`timescale 1ns/1ps
`default_nettype none
module iop_ports (
   input  wire logic       core_clk,
   input  wire logic       reset,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic      [7:0] rdata,
   input  wire logic [7:0] pc_in,
   output logic      [7:0] pc_out,
   output logic      [7:0] pc_oe,
   input  wire logic [7:0] periph_en,
   input  wire logic [7:0] periph_oe,
   input  wire logic [7:0] periph_out,
   output logic      [7:0] pc_value,
   input  wire logic [7:0] pd_in,
   output logic      [7:0] pd_out,
   output logic      [7:0] pd_oe,
   input  wire logic [2:0] pe_in,
   output logic      [2:0] pe_out,
   output logic      [2:0] pe_oe
);
   import iop_pkg::*;

   typedef struct packed {
      logic [7:0] c_lat;
      logic [7:0] c_dir;
      logic [7:0] d_lat;
      logic [7:0] d_dir;
      logic [7:0] d_in;
      logic [2:0] e_lat;
      logic [7:0] e_ctl;
      logic [2:0] ana;
      logic [7:0] rdata;
      logic [7:0] pc_out;
      logic [7:0] pc_oe;
      logic [7:0] pc_value;
      logic [7:0] pd_out;
      logic [7:0] pd_oe;
      logic [2:0] pe_out;
      logic [2:0] pe_oe;
   } iop_ports_st_t;

   iop_ports_st_t st;
   iop_ports_st_t next_st;

   logic [SYNC_W-1:0] pins_s;
   logic [7:0]        pc_s;
   logic [7:0]        pd_s;
   logic [2:0]        pe_s;
   logic [7:0]        eff_cdir;
   logic              mode;
   logic              wr_low;
   logic              rd_pd;
   logic              wr_ctl;

   iop_psp_if pif ();

   // all pins pass three stages before any use
   iop_sync #(
      .W    (SYNC_W),
      .INIT (SYNC_INIT)
   ) u_sync (
      .core_clk (core_clk),
      .reset    (reset),
      .d        ({pe_in, pd_in, pc_in}),
      .q        (pins_s)
   );

   assign pc_s = pins_s[7:0];
   assign pd_s = pins_s[15:8];
   assign pe_s = pins_s[18:16];

   assign mode     = st.e_ctl[MODE_POS];
   assign pif.mode = mode;
   assign pif.rd_n = pe_s[0];
   assign pif.wr_n = pe_s[1];
   assign pif.cs_n = pe_s[2];

   iop_psp u_psp (
      .core_clk (core_clk),
      .reset    (reset),
      .bus      (pif.ctl)
   );

   // effective direction, one is input
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         eff_cdir[i] = periph_en[i] ? ~periph_oe[i] : st.c_dir[i];
      end
   end

   assign wr_low = mode & ~pif.cs_n & ~pif.wr_n;
   assign rd_pd  = rd && (addr == ADDR_D_DATA);
   assign wr_ctl = wr && (addr == ADDR_E_CTL);

   always_comb begin
      next_st       = st;
      next_st.rdata = 8'h00;

      if (rd) begin
         case (addr)
            ADDR_C_DATA: next_st.rdata = pc_s;
            // read-back shows the override, so bit updates are unsafe
            ADDR_C_DIR:  next_st.rdata = eff_cdir;
            ADDR_D_DATA: next_st.rdata = mode ? st.d_in : pd_s;
            ADDR_D_DIR:  next_st.rdata = st.d_dir;
            ADDR_E_DATA: next_st.rdata =
               {5'h00, pe_s & ~iop_pe_analog(st.ana)};
            ADDR_E_CTL:  next_st.rdata = st.e_ctl;
            ADDR_ANA:    next_st.rdata = {5'h00, st.ana};
            default:     next_st.rdata = 8'h00;
         endcase
      end

      if (wr) begin
         case (addr)
            ADDR_C_DATA: next_st.c_lat = wdata;
            ADDR_C_DIR:  next_st.c_dir = wdata;
            ADDR_D_DATA: next_st.d_lat = wdata;
            ADDR_D_DIR:  next_st.d_dir = wdata;
            ADDR_E_DATA: next_st.e_lat = wdata[2:0];
            ADDR_E_CTL: begin
               // full flags belong to hardware
               next_st.e_ctl[INPUT_OVERFLOW_FLAG_POS] = wdata[INPUT_OVERFLOW_FLAG_POS];
               next_st.e_ctl[MODE_POS] = wdata[MODE_POS];
               next_st.e_ctl[2:0]      = wdata[2:0];
            end
            ADDR_ANA:    next_st.ana = wdata[2:0];
            default:     next_st.ana = st.ana;
         endcase
      end

      // capture while the strobe is still low, not at its release
      if (wr_low) begin
         next_st.d_in = pd_s;
      end

      if (rd_pd && mode) begin
         next_st.e_ctl[IBF_POS] = 1'b0;
      end
      if (pif.rd_start) begin
         next_st.e_ctl[OBF_POS] = 1'b0;
      end
      // a firmware write of the latch wins over a same-cycle read start
      if (wr && addr == ADDR_D_DATA && mode) begin
         next_st.e_ctl[OBF_POS] = 1'b1;
      end
      // the hardware event wins over a same-cycle read clear, not over a slave mode exit
      if (pif.wr_end) begin
         if (st.e_ctl[IBF_POS]) begin
            next_st.e_ctl[INPUT_OVERFLOW_FLAG_POS] = 1'b1;
         end
         next_st.e_ctl[IBF_POS] = 1'b1;
      end
      if (!next_st.e_ctl[MODE_POS]) begin
         next_st.e_ctl[IBF_POS] = 1'b0;
         next_st.e_ctl[OBF_POS] = 1'b0;
      end
      next_st.e_ctl[NC_POS] = 1'b0;

      for (int i = 0; i < 8; i++) begin
         next_st.pc_oe[i]  = ~eff_cdir[i];
         next_st.pc_out[i] = periph_en[i] ? periph_out[i]
                                          : st.c_lat[i];
      end
      next_st.pc_value = pc_s;

      next_st.pd_out = st.d_lat;
      if (mode) begin
         next_st.pd_oe = {8{pif.rd_act}};
      end else begin
         next_st.pd_oe = ~st.d_dir;
      end

      // analog pins still obey direction; slave mode makes them inputs
      next_st.pe_out = st.e_lat;
      next_st.pe_oe  = mode ? 3'h0 : ~st.e_ctl[2:0];
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         st       <= '0;
         st.c_dir <= RST_C_DIR;
         st.d_dir <= RST_D_DIR;
         st.c_lat <= RST_LATCH;
         st.d_lat <= RST_LATCH;
         st.e_ctl <= RST_E_CTL;
         st.ana   <= RST_ANA;
      end else begin
         st <= next_st;
      end
   end

   assign rdata    = st.rdata;
   assign pc_out   = st.pc_out;
   assign pc_oe    = st.pc_oe;
   assign pc_value = st.pc_value;
   assign pd_out   = st.pd_out;
   assign pd_oe    = st.pd_oe;
   assign pe_out   = st.pe_out;
   assign pe_oe    = st.pe_oe;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);

   a_pc_dir_plain: assert property (
      (periph_en == 8'h00) |=> (pc_oe == ~$past(st.c_dir)))
      else $error("port c drive does not follow direction");

   a_pc_override: assert property (
      periph_en[3] |=> (pc_oe[3] == $past(periph_oe[3])
                        && pc_out[3] == $past(periph_out[3])))
      else $error("peripheral override on port c lost");

   a_pd_slave_quiet: assert property (
      (mode && !pif.rd_act) |=> (pd_oe == 8'h00))
      else $error("port d driven in slave mode without a read");

   a_pd_slave_read: assert property (
      (mode && pif.rd_act) |=> (pd_oe == 8'hff && pd_out == $past(st.d_lat)))
      else $error("slave read did not drive the latch");

   a_ibf_set: assert property (
      (pif.wr_end && mode && !wr_ctl) |=> st.e_ctl[IBF_POS])
      else $error("input full flag not set after write");

   a_ibf_hold: assert property (
      (st.e_ctl[IBF_POS] && !rd_pd && !wr_ctl) |=> st.e_ctl[IBF_POS])
      else $error("input full flag cleared without a read");

   a_input_overflow_flag_set: assert property (
      (pif.wr_end && st.e_ctl[IBF_POS]) |=> st.e_ctl[INPUT_OVERFLOW_FLAG_POS])
      else $error("overflow not flagged on second write");

   a_pe_analog_zero: assert property (
      (rd && addr == ADDR_E_DATA && iop_pe_analog(st.ana) == 3'h7)
      |=> (rdata == 8'h00))
      else $error("analog port e pin read as nonzero");

   a_reset_analog: assert property (
      $past(reset) |-> (iop_pe_analog(st.ana) == 3'h7))
      else $error("port e not analog after reset");

   a_pe_slave_input: assert property (
      mode |=> (pe_oe == 3'h0))
      else $error("port e driven in slave mode");

   a_rdata_idle: assert property (
      !rd |=> (rdata == 8'h00))
      else $error("read data outside the read answer cycle");
endmodule : iop_ports
`default_nettype wire

// >>> test/iop_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module iop_bus_model (
   input  wire logic       core_clk,
   input  wire logic [7:0] pc_ext,
   input  wire logic [7:0] pc_out,
   input  wire logic [7:0] pc_oe,
   input  wire logic [7:0] pd_out,
   input  wire logic [7:0] pd_oe,
   input  wire logic [2:0] pe_out,
   input  wire logic [2:0] pe_oe,
   output logic      [7:0] pc_in,
   output logic      [7:0] pd_in,
   output logic      [2:0] pe_in
);
   logic [7:0] drv = 8'h00;
   logic       rel = 1'b0;
   logic [2:0] ctl = 3'h7;
   // released data lines show the inverse, never a stale byte
   always_comb pd_in = (pd_oe & pd_out) | (~pd_oe & (rel ? ~drv : drv));
   always_comb pc_in = (pc_oe & pc_out) | (~pc_oe & pc_ext);
   always_comb pe_in = (pe_oe & pe_out) | (~pe_oe & ctl);
   // c = {select, write, read}, low active; held until release
   task automatic xfer(input logic [2:0] c, input logic [7:0] d,
                       input int hold, output logic [7:0] q);
      @(posedge core_clk);
      drv <= d;
      rel <= ~c[0];
      ctl <= c;
      repeat (hold) @(posedge core_clk);
      q = pd_in;
      // data lines let go with the strobe, so a late capture shows
      ctl <= 3'h7;
      rel <= 1'b1;
      repeat (8) @(posedge core_clk);
   endtask : xfer
endmodule : iop_bus_model
`default_nettype wire

// >>> test/iop_ports_test.sv
`timescale 1ns/1ps
`default_nettype none
module iop_ports_test;
   import iop_pkg::*;
   typedef struct {
      string      name;
      logic [7:0] val;
   } iop_note_t;
   logic        core_clk   = 1'b0;
   logic        reset      = 1'b1;
   logic [7:0]  addr       = 8'h00;
   logic [7:0]  wdata      = 8'h00;
   logic        wr         = 1'b0;
   logic        rd         = 1'b0;
   logic [7:0]  periph_en  = 8'h00;
   logic [7:0]  periph_oe  = 8'h00;
   logic [7:0]  periph_out = 8'h00;
   logic [7:0]  pc_ext     = 8'h3c;
   logic [7:0]  rdata, pc_out, pc_oe, pc_value, pd_out, pd_oe;
   logic [7:0]  pc_in, pd_in, en, oe, pin, q;
   logic [2:0]  pe_in, pe_out, pe_oe;
   logic        rd_seen    = 1'b0;
   logic [31:0] seed       = 32'd60666;
   int          num_checks = 0;
   int          fail_count = 0;
   int          cycles     = 0;
   iop_note_t   notes[$];
   iop_note_t   note;

   iop_ports uut (.core_clk(core_clk), .reset(reset), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pc_in(pc_in),
      .pc_out(pc_out), .pc_oe(pc_oe), .periph_en(periph_en),
      .periph_oe(periph_oe), .periph_out(periph_out),
      .pc_value(pc_value), .pd_in(pd_in), .pd_out(pd_out),
      .pd_oe(pd_oe), .pe_in(pe_in), .pe_out(pe_out), .pe_oe(pe_oe));
   iop_bus_model m (.core_clk(core_clk), .pc_ext(pc_ext),
      .pc_out(pc_out), .pc_oe(pc_oe), .pd_out(pd_out), .pd_oe(pd_oe),
      .pe_out(pe_out), .pe_oe(pe_oe), .pc_in(pc_in), .pd_in(pd_in),
      .pe_in(pe_in));

   initial begin
      forever #4 core_clk = ~core_clk;
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
   endfunction : xs

   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : complete_run

   task automatic check(input string n, input logic [7:0] s, e);
      num_checks++;
      if (s !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask : check

   task automatic reg_wr(input logic [7:0] a, d);
      @(posedge core_clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge core_clk);
      wr <= 1'b0;
   endtask : reg_wr

   task automatic reg_rd(input logic [7:0] a, e, input string n);
      @(posedge core_clk);
      addr <= a;
      rd   <= 1'b1;
      notes.push_back('{n, e});
      @(posedge core_clk);
      rd <= 1'b0;
   endtask : reg_rd

   // read data is valid only in the cycle after the strobe
   always @(posedge core_clk) begin
      if (rd_seen) begin
         note = notes.pop_front();
         check(note.name, rdata, note.val);
      end
      rd_seen <= rd;
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         complete_run();
      end
   end

   initial begin
      repeat (8) @(posedge core_clk);
      reset <= 1'b0;
      reg_rd(ADDR_C_DIR, 8'hff, "c_dir");
      reg_rd(ADDR_D_DIR, 8'hff, "d_dir");
      reg_rd(ADDR_E_CTL, 8'h07, "e_ctl");
      reg_rd(ADDR_ANA, 8'h00, "ana");
      reg_rd(ADDR_E_DATA, 8'h00, "e_data");
      reg_rd(8'h00, 8'h00, "unmapped");
      reg_rd(ADDR_C_DATA, 8'h3c, "c_data");
      reg_wr(ADDR_C_DATA, 8'ha5);
      reg_wr(ADDR_C_DIR, 8'h0f);
      for (int i = 0; i < 6; i++) begin
         seed = xs(seed);
         en = (i < 2) ? 8'h00 : seed[7:0];
         oe = (en & seed[15:8]) | (~en & 8'hf0);
         pin = (en & seed[23:16]) | (~en & 8'ha5);
         pin = (oe & pin) | (~oe & seed[31:24]);
         @(posedge core_clk);
         periph_en  <= en;
         periph_oe  <= seed[15:8];
         periph_out <= seed[23:16];
         pc_ext     <= seed[31:24];
         // pin to sync output takes four edges, one more to pc_value
         repeat (8) @(posedge core_clk);
         check("pc_oe", pc_oe, oe);
         check("pc_out", pc_out & oe, pin & oe);
         check("pc_value", pc_value, pin);
         reg_rd(ADDR_C_DIR, ~oe, "c_dir");
         reg_rd(ADDR_C_DATA, pin, "c_data");
      end
      reg_wr(ADDR_D_DATA, 8'h96);
      reg_wr(ADDR_D_DIR, 8'h0f);
      repeat (2) @(posedge core_clk);
      check("pd_oe", pd_oe, 8'hf0);
      check("pd_out", pd_out & 8'hf0, 8'h90);
      repeat (4) @(posedge core_clk);
      reg_rd(ADDR_D_DATA, 8'h90, "d_data");
      reg_wr(ADDR_ANA, 8'h06);
      repeat (5) @(posedge core_clk);
      reg_rd(ADDR_E_DATA, 8'h07, "e_data");
      reg_wr(ADDR_E_DATA, 8'h01);
      reg_wr(ADDR_E_CTL, 8'h02);
      repeat (6) @(posedge core_clk);
      check("pe_oe", 8'(pe_oe), 8'h05);
      check("pe_out", 8'(pe_out & 3'h5), 8'h01);
      reg_rd(ADDR_E_DATA, 8'h03, "e_data");
      reg_wr(ADDR_ANA, 8'h00);
      repeat (2) @(posedge core_clk);
      check("pe_oe", 8'(pe_oe), 8'h05);
      reg_rd(ADDR_E_DATA, 8'h00, "e_data");
      // firmware prepares digital inputs before slave mode
      reg_wr(ADDR_E_CTL, 8'h07);
      reg_wr(ADDR_ANA, 8'h06);
      reg_wr(ADDR_D_DIR, 8'h00);
      reg_wr(ADDR_E_CTL, 8'h17);
      reg_wr(ADDR_D_DATA, 8'h3c);
      repeat (2) @(posedge core_clk);
      check("pd_oe", pd_oe, 8'h00);
      check("pe_oe", 8'(pe_oe), 8'h00);
      reg_rd(ADDR_E_CTL, 8'h57, "e_ctl");
      m.xfer(3'h5, 8'hc3, 8, q);
      reg_rd(ADDR_E_CTL, 8'h57, "e_ctl");
      m.xfer(3'h1, 8'h5a, 8, q);
      reg_rd(ADDR_E_CTL, 8'hd7, "e_ctl");
      reg_rd(ADDR_D_DATA, 8'h5a, "d_in");
      reg_rd(ADDR_E_CTL, 8'h57, "e_ctl");
      m.xfer(3'h2, 8'h00, 16, q);
      check("psp_rd", q, 8'h3c);
      reg_rd(ADDR_E_CTL, 8'h17, "e_ctl");
      m.xfer(3'h1, 8'h11, 8, q);
      m.xfer(3'h1, 8'h22, 16, q);
      reg_rd(ADDR_E_CTL, 8'hb7, "e_ctl");
      reg_rd(ADDR_D_DATA, 8'h22, "d_in");
      reg_rd(ADDR_E_CTL, 8'h37, "e_ctl");
      reg_wr(ADDR_E_CTL, 8'h17);
      reg_rd(ADDR_E_CTL, 8'h17, "e_ctl");
      repeat (2) @(posedge core_clk);
      complete_run();
   end
endmodule : iop_ports_test
`default_nettype wire
